// file: ast_baud.sv
// Shared rate generator giving the sixteen-times receive sample tick.
`timescale 1ns/100ps
`default_nettype none
`include "ast_defs.svh"
module ast_baud
  import ast_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] rate_sel,
  output logic            rt_tick
);
  ast_baud_state_t st;
  ast_baud_state_t next_st;
  logic [11:0]     limit;

  // One divider feeds both directions, so they can never drift apart.
  assign limit = 12'(({7'h00, rate_sel} + 12'h001) * `AST_BAUD_UNIT) - 12'h001;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= limit) begin
      next_st.cnt  = 12'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rt_tick = st.tick;
endmodule : ast_baud
`default_nettype wire

// file: ast_defs.svh
// Register offsets, field positions, sample points and counts of the transceiver.
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
`define AST_ADDR_DATA   8'h00
`define AST_ADDR_FMT    8'h01
`define AST_ADDR_ENA    8'h02
`define AST_ADDR_STAT   8'h03
`define AST_ADDR_BAUD   8'h04
`define AST_FMT_R8      7
`define AST_FMT_T8      6
`define AST_FMT_M       4
`define AST_FMT_WAKE    3
`define AST_ENA_TIE     7
`define AST_ENA_TX_DONE_IRQ_EN    6
`define AST_ENA_RIE     5
`define AST_ENA_ILIE    4
`define AST_ENA_TE      3
`define AST_ENA_RE      2
`define AST_ENA_RWU     1
`define AST_ENA_SBK     0
`define AST_BAUD_MSB    4
`define AST_BAUD_UNIT   12'h008
`define AST_BITS8       4'h8
`define AST_BITS9       4'h9
`define AST_RT_V1       4'h2
`define AST_RT_V2       4'h4
`define AST_RT_V3       4'h6
`define AST_RT_S1       4'h7
`define AST_RT_S2       4'h8
`define AST_RT_S3       4'h9
`define AST_RT_LAST     4'hF
`define AST_IDLE_TICKS8 8'hA0
`define AST_IDLE_TICKS9 8'hB0
`define AST_IDLE_SAT    8'hFF
`endif

// file: ast_peer.sv
// Far-end serial node: sends characters on the receive line, decodes the transmit line.
`timescale 1ns/100ps
`default_nettype none
module ast_peer (
  input  wire logic       clk,
  input  wire logic [4:0] rate,
  input  wire logic       nine,
  input  wire logic       tx_line,
  output var  logic       rx_line
);
  logic [9:0] got_q[$];
  int         bit_clks;

  always_comb bit_clks = (int'(rate) + 1) * 128;

  initial rx_line = 1'b1;

  task automatic hold(input logic lvl, input int n);
    rx_line <= lvl;
    repeat (n) @(posedge clk);
  endtask : hold

  // A glitch of eight clocks (one sample tick at rate 0) lands in the middle of data bit gbit.
  task automatic send(input logic [8:0] d, input logic stop, input int gbit);
    int i;
    hold(1'b0, bit_clks);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      if (i == gbit) begin
        hold(d[i], bit_clks / 2);
        hold(~d[i], 8);
        hold(d[i], bit_clks / 2 - 8);
      end else begin
        hold(d[i], bit_clks);
      end
    end
    hold(stop, bit_clks);
    // A bad stop bit is followed by one idle bit so the line rests high.
    if (!stop)
      hold(1'b1, bit_clks);
  endtask : send

  // Each frame is sampled mid-bit; a long low level yields one all-zero entry.
  always begin : watch
    int         i;
    logic [9:0] w;
    @(negedge tx_line);
    repeat (bit_clks / 2) @(posedge clk);
    w = '0;
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_clks) @(posedge clk);
      w[i] = tx_line;
    end
    repeat (bit_clks) @(posedge clk);
    w[9] = tx_line;
    got_q.push_back(w);
  end
endmodule : ast_peer
`default_nettype wire

// file: ast_pkg.sv
// Types shared by the transceiver modules.
`default_nettype none
package ast_pkg;
  typedef enum logic [0:0] {
    AST_RX_IDLE  = 1'b0,
    AST_RX_FRAME = 1'b1
  } ast_rx_state_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
  } ast_baud_state_t;

  typedef struct packed {
    logic [7:0]    tdr;
    logic          t8, m, wake;
    logic          tie, tx_done_irq_en, rie, ilie, te, re, rx_sleep_ctrl, send_break_ctrl;
    logic [4:0]    baud;
    logic          tx_buffer_empty_flag, tc, rx_buffer_full_flag, idle, ovr, nf, fe;
    logic [7:0]    rdr;
    logic          r8, armed, irq;
    logic [7:0]    rdata;
    logic          tx_line, owned, tx_active;
    logic [9:0]    tx_sh;
    logic [3:0]    tx_cnt, tx_rt;
    ast_rx_state_t rx_state;
    logic [3:0]    rx_rt, rx_bit;
    logic [1:0]    rx_samp;
    logic [8:0]    rx_shift;
    logic          rx_noise, rx_prev_high, got_char;
    logic [7:0]    rx_idle_cnt;
  } ast_state_t;
endpackage : ast_pkg
`default_nettype wire

// file: ast_serial.sv
// Asynchronous serial transceiver with register port, wake-up and error flags.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ast_defs.svh"
module ast_serial
  import ast_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  input  wire logic       serial_rx_line,
  output logic            serial_tx_line,
  output logic            tx_pin_owned,
  output logic            irq_req
);
  ast_state_t st;
  ast_state_t next_st;
  logic       rt_tick;
  logic       tx_bit_tick;
  logic       wr_data;
  logic       v_level;
  logic       v_noisy;
  logic [3:0] nbits;
  logic [7:0] idle_thr;
  logic       rx_brk;
  logic       rx_take;
  logic [7:0] rx_char;

  ast_baud u_baud (
    .clk      (clk),
    .rst      (rst),
    .rate_sel (st.baud),
    .rt_tick  (rt_tick)
  );

  // The same voter serves the start check and the bit decision.
  ast_vote u_vote (
    .samples ({st.rx_samp, serial_rx_line}),
    .level   (v_level),
    .noisy   (v_noisy)
  );

  assign nbits       = st.m ? `AST_BITS9 : `AST_BITS8;
  assign idle_thr    = st.m ? `AST_IDLE_TICKS9 : `AST_IDLE_TICKS8;
  assign tx_bit_tick = rt_tick && (st.tx_rt == `AST_RT_LAST);
  assign wr_data     = bus_wr && (bus_addr == `AST_ADDR_DATA);
  // An all-zero character with a low stop bit is a break.
  assign rx_brk  = !v_level && (st.m ? (st.rx_shift == 9'h000)
                                     : (st.rx_shift[8:1] == 8'h00));
  assign rx_take = !st.rx_sleep_ctrl || (st.wake && st.rx_shift[8]);
  assign rx_char = st.m ? st.rx_shift[7:0] : st.rx_shift[8:1];

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // Register reads return the state before this cycle's updates.
    if (bus_rd) begin
      case (bus_addr)
        `AST_ADDR_DATA: next_st.rdata = st.rdr;
        `AST_ADDR_FMT:  next_st.rdata = {st.r8, st.t8, 1'b0, st.m,
                                         st.wake, 3'b000};
        `AST_ADDR_ENA:  next_st.rdata = {st.tie, st.tx_done_irq_en, st.rie, st.ilie,
                                         st.te, st.re, st.rx_sleep_ctrl, st.send_break_ctrl};
        `AST_ADDR_STAT: next_st.rdata = {st.tx_buffer_empty_flag, st.tc, st.rx_buffer_full_flag, st.idle,
                                         st.ovr, st.nf, st.fe, 1'b0};
        `AST_ADDR_BAUD: next_st.rdata = {3'b000, st.baud};
        default:        next_st.rdata = 8'h00;
      endcase
    end
    if (bus_wr) begin
      case (bus_addr)
        `AST_ADDR_DATA: begin
          next_st.tdr  = bus_wdata;
          next_st.tx_buffer_empty_flag = 1'b0;
          next_st.tc   = 1'b0;
        end
        `AST_ADDR_FMT: begin
          next_st.t8   = bus_wdata[`AST_FMT_T8];
          next_st.m    = bus_wdata[`AST_FMT_M];
          next_st.wake = bus_wdata[`AST_FMT_WAKE];
        end
        `AST_ADDR_ENA: begin
          next_st.tie  = bus_wdata[`AST_ENA_TIE];
          next_st.tx_done_irq_en = bus_wdata[`AST_ENA_TX_DONE_IRQ_EN];
          next_st.rie  = bus_wdata[`AST_ENA_RIE];
          next_st.ilie = bus_wdata[`AST_ENA_ILIE];
          next_st.te   = bus_wdata[`AST_ENA_TE];
          next_st.re   = bus_wdata[`AST_ENA_RE];
          next_st.rx_sleep_ctrl  = bus_wdata[`AST_ENA_RWU];
          next_st.send_break_ctrl  = bus_wdata[`AST_ENA_SBK];
        end
        `AST_ADDR_BAUD: next_st.baud = bus_wdata[`AST_BAUD_MSB:0];
        default: ;
      endcase
    end
    // Receive flags clear by a status read followed by a data read.
    if (bus_rd && (bus_addr == `AST_ADDR_STAT)) begin
      next_st.armed = 1'b1;
    end
    if ((bus_rd || bus_wr) && (bus_addr == `AST_ADDR_DATA)) begin
      next_st.armed = 1'b0;
      if (bus_rd && st.armed) begin
        next_st.rx_buffer_full_flag = 1'b0;
        next_st.idle = 1'b0;
        next_st.ovr  = 1'b0;
        next_st.nf   = 1'b0;
        next_st.fe   = 1'b0;
      end
    end

    // Transmitter; the updates below come after the clears so a set wins.
    if (rt_tick) begin
      next_st.tx_rt = st.tx_rt + 4'h1;
    end
    if (tx_bit_tick) begin
      if (st.tx_cnt != 4'h0) begin
        next_st.tx_line = st.tx_sh[0];
        next_st.tx_sh   = {1'b1, st.tx_sh[9:1]};
        next_st.tx_cnt  = st.tx_cnt - 4'h1;
      end else if (st.te && !st.tx_buffer_empty_flag && !wr_data) begin
        next_st.tx_line   = 1'b0;
        next_st.tx_sh     = st.m ? {1'b1, st.t8, st.tdr} : {2'b11, st.tdr};
        next_st.tx_cnt    = nbits + 4'h1;
        next_st.tx_buffer_empty_flag      = 1'b1;
        next_st.tx_active = 1'b1;
      end else if (st.te && st.send_break_ctrl) begin
        next_st.tx_line   = 1'b0;
        next_st.tx_sh     = 10'h000;
        next_st.tx_cnt    = nbits + 4'h1;
        next_st.tx_active = 1'b1;
      end else begin
        next_st.tx_line = 1'b1;
        if (st.tx_active) begin
          next_st.tx_active = 1'b0;
          next_st.tc        = 1'b1;
        end
      end
    end
    // The pin stays ours until the frame in flight has gone out.
    next_st.owned = next_st.te || next_st.tx_active;

    // Receiver.
    if (!st.re) begin
      next_st.rx_state    = AST_RX_IDLE;
      next_st.rx_idle_cnt = 8'h00;
    end else if (rt_tick) begin
      case (st.rx_state)
        AST_RX_IDLE: begin
          next_st.rx_prev_high = serial_rx_line;
          if (!serial_rx_line) begin
            next_st.rx_idle_cnt = 8'h00;
            if (st.rx_prev_high) begin
              next_st.rx_state = AST_RX_FRAME;
              next_st.rx_rt    = 4'h0;
              next_st.rx_bit   = 4'h0;
              next_st.rx_samp  = 2'b00;
              next_st.rx_noise = 1'b0;
            end
          end else if (st.rx_idle_cnt != `AST_IDLE_SAT) begin
            next_st.rx_idle_cnt = st.rx_idle_cnt + 8'h01;
            if (next_st.rx_idle_cnt == idle_thr) begin
              if (st.rx_sleep_ctrl) begin
                if (!st.wake) begin
                  next_st.rx_sleep_ctrl = 1'b0;
                end
              end else if (st.got_char) begin
                next_st.idle     = 1'b1;
                next_st.got_char = 1'b0;
              end
            end
          end
        end
        AST_RX_FRAME: begin
          next_st.rx_rt = st.rx_rt + 4'h1;
          if (st.rx_rt == `AST_RT_LAST) begin
            next_st.rx_bit = st.rx_bit + 4'h1;
          end
          if ((st.rx_rt == `AST_RT_V1) || (st.rx_rt == `AST_RT_V2) ||
              (st.rx_rt == `AST_RT_S1) || (st.rx_rt == `AST_RT_S2)) begin
            next_st.rx_samp = {st.rx_samp[0], serial_rx_line};
          end
          if ((st.rx_bit == 4'h0) && (st.rx_rt == `AST_RT_V3)) begin
            if (v_level) begin
              next_st.rx_state = AST_RX_IDLE;
            end else begin
              next_st.rx_noise = st.rx_noise | v_noisy;
            end
          end
          if (st.rx_rt == `AST_RT_S3) begin
            if (st.rx_bit == 4'h0) begin
              next_st.rx_noise = st.rx_noise | v_noisy;
            end else if (st.rx_bit <= nbits) begin
              next_st.rx_noise = st.rx_noise | v_noisy;
              next_st.rx_shift = {v_level, st.rx_shift[8:1]};
            end else begin
              // Stop bit: decide the character and leave the frame early.
              if (st.rx_sleep_ctrl && rx_take) begin
                next_st.rx_sleep_ctrl = 1'b0;
              end
              if (rx_take) begin
                if (st.rx_buffer_full_flag) begin
                  next_st.ovr = 1'b1;
                end else begin
                  next_st.rdr  = rx_char;
                  next_st.r8   = st.rx_shift[8];
                  next_st.rx_buffer_full_flag = 1'b1;
                end
                next_st.nf = st.nf | st.rx_noise | v_noisy;
                next_st.fe = st.fe | !v_level;
                if (v_level) begin
                  next_st.got_char = 1'b1;
                end
              end
              next_st.rx_state     = AST_RX_IDLE;
              next_st.rx_idle_cnt  = 8'h00;
              // A low stop bit, break or not, must see the line high again,
              // so the rest of a bad stop bit is never taken as a start.
              next_st.rx_prev_high = v_level && !rx_brk;
            end
          end
        end
        default: next_st.rx_state = AST_RX_IDLE;
      endcase
    end

    next_st.irq = (next_st.tie && next_st.tx_buffer_empty_flag) ||
                  (next_st.tx_done_irq_en && next_st.tc) ||
                  (next_st.rie && (next_st.rx_buffer_full_flag || next_st.ovr)) ||
                  (next_st.ilie && next_st.idle);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st              <= '0;
      st.tx_buffer_empty_flag         <= 1'b1;
      st.tc           <= 1'b1;
      st.tx_line      <= 1'b1;
      st.rx_state     <= AST_RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata      = st.rdata;
  assign serial_tx_line = st.tx_line;
  assign tx_pin_owned   = st.owned;
  assign irq_req        = st.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_tx_start_low: assert property (
    $rose(st.tx_active) |-> !serial_tx_line)
    else $error("Frame did not open with a low start bit.");
  chk_tx_rest_high: assert property (
    !st.tx_active |-> serial_tx_line)
    else $error("Transmit line low while no frame is active.");
  chk_tx_buffer_empty_flag_on_load: assert property (
    $rose(st.tx_buffer_empty_flag) |-> st.tx_active && !serial_tx_line && $past(tx_bit_tick))
    else $error("Empty flag set without a load into the shifter.");
  chk_tc_frame_end: assert property (
    $rose(st.tc) |-> !st.tx_active && serial_tx_line && $past(st.tx_active))
    else $error("Done flag set while a frame is still going out.");
  chk_pin_kept_busy: assert property (
    st.tx_active |-> tx_pin_owned)
    else $error("Transmit pin released during a frame.");
  chk_tx_bit_edge: assert property (
    $changed(serial_tx_line) |-> $past(tx_bit_tick))
    else $error("Transmit line moved off a bit boundary.");
  chk_rx_buffer_full_flag_irq_req: assert property (
    (st.rx_buffer_full_flag && st.rie) |-> irq_req)
    else $error("Full flag with enable gave no interrupt request.");
  chk_sleep_no_flag: assert property (
    st.rx_sleep_ctrl |-> !$rose(st.rx_buffer_full_flag) && !$rose(st.idle) && !$rose(st.fe))
    else $error("Receive flag rose while the receiver sleeps.");
  chk_idle_after_char: assert property (
    $rose(st.idle) |-> $past(st.got_char))
    else $error("Idle flag set with no character received.");

  cov_tx_done:  cover property ($rose(st.tc));
  cov_rx_full:  cover property ($rose(st.rx_buffer_full_flag));
  cov_rx_idle:  cover property ($rose(st.idle));
  cov_rx_break: cover property ($rose(st.fe) && (st.rdr == 8'h00));
endmodule : ast_serial
`default_nettype wire

// file: ast_serial_tb_top.sv
// Self-checking bench for the serial transceiver against a far-end node.
`timescale 1ns/100ps
`default_nettype none
`include "ast_defs.svh"
module ast_serial_tb_top;
  logic       clk       = 1'b0;
  logic       rst       = 1'b1;
  logic [7:0] bus_addr  = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic       bus_wr    = 1'b0;
  logic       bus_rd    = 1'b0;
  logic [7:0] bus_rdata;
  logic       rx_line;
  logic       serial_tx_line;
  logic       tx_pin_owned;
  logic       irq_req;
  logic [4:0] rate_sel  = 5'h00;
  logic       nine      = 1'b0;
  logic [7:0] d;
  int         failures   = 0;
  int         num_checks = 0;
  int         cyc        = 0;

  always #4 clk = ~clk;

  ast_serial dut (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .serial_rx_line(rx_line), .serial_tx_line(serial_tx_line),
    .tx_pin_owned(tx_pin_owned), .irq_req(irq_req));

  ast_peer peer (
    .clk(clk), .rate(rate_sel), .nine(nine), .tx_line(serial_tx_line),
    .rx_line(rx_line));

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Order of the pin triple: transmit line, pin ownership, interrupt.
  task automatic pins(input logic [2:0] e);
    chk({7'h0, serial_tx_line, tx_pin_owned, irq_req}, {7'h0, e});
  endtask : pins

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, m, e);
    logic [7:0] v;
    rd(a, v);
    chk({2'b00, v & m}, {2'b00, e});
  endtask : rchk

  task automatic bits(input int n);
    repeat (n * (int'(rate_sel) + 1) * 128) @(posedge clk);
    #1;
  endtask : bits

  // An empty queue yields a value that can never match.
  task automatic pop(input logic [9:0] e);
    logic [9:0] w;
    w = 10'h3FF ^ e;
    if (peer.got_q.size() > 0)
      w = peer.got_q.pop_front();
    chk(w, e);
  endtask : pop

  // Lets the idle flag come up, then clears every receive flag.
  task automatic drain;
    bits(12);
    rd(`AST_ADDR_STAT, d);
    rd(`AST_ADDR_DATA, d);
  endtask : drain

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      $display("BAD %0t run took too long", $time);
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pins(3'b100);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    rchk(`AST_ADDR_ENA, 8'hFF, 8'h00);
    rchk(`AST_ADDR_FMT, 8'hFF, 8'h00);
    rchk(`AST_ADDR_BAUD, 8'hFF, 8'h00);
    wr(8'h07, 8'hFF);
    rchk(8'h07, 8'hFF, 8'h00);
    done("reset");
    wr(`AST_ADDR_ENA, 8'h48);
    pins(3'b111);
    wr(`AST_ADDR_DATA, 8'hA5);
    bits(2);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'h80);
    wr(`AST_ADDR_DATA, 8'h3C);
    bits(22);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    pins(3'b111);
    pop(10'h2A5);
    pop(10'h23C);
    done("transmit");
    wr(`AST_ADDR_FMT, 8'h50);
    nine <= 1'b1;
    wr(`AST_ADDR_DATA, 8'h5A);
    bits(13);
    pop(10'h35A);
    wr(`AST_ADDR_FMT, 8'h00);
    nine <= 1'b0;
    done("nine bits");
    wr(`AST_ADDR_DATA, 8'hC3);
    bits(3);
    wr(`AST_ADDR_ENA, 8'h00);
    chk({9'h0, tx_pin_owned}, 10'h001);
    bits(9);
    pins(3'b100);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    pop(10'h2C3);
    done("disable");
    wr(`AST_ADDR_ENA, 8'h09);
    bits(12);
    pins(3'b010);
    wr(`AST_ADDR_ENA, 8'h08);
    bits(12);
    pins(3'b110);
    pop(10'h000);
    wr(`AST_ADDR_ENA, 8'h00);
    done("break");
    wr(`AST_ADDR_ENA, 8'h24);
    bits(12);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    wr(`AST_ADDR_ENA, 8'h34);
    peer.send(9'h096, 1'b1, -1);
    pins(3'b101);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hE0);
    rchk(`AST_ADDR_DATA, 8'hFF, 8'h96);
    pins(3'b100);
    bits(12);
    pins(3'b101);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hD0);
    rd(`AST_ADDR_DATA, d);
    done("receive");
    wr(`AST_ADDR_ENA, 8'h24);
    peer.send(9'h011, 1'b1, -1);
    peer.send(9'h022, 1'b1, -1);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hE8);
    rchk(`AST_ADDR_DATA, 8'hFF, 8'h11);
    drain();
    peer.send(9'h055, 1'b0, -1);
    rchk(`AST_ADDR_STAT, 8'h0E, 8'h02);
    drain();
    peer.send(9'h03C, 1'b1, 2);
    rchk(`AST_ADDR_STAT, 8'h0E, 8'h04);
    rchk(`AST_ADDR_DATA, 8'hFF, 8'h3C);
    drain();
    done("errors");
    wr(`AST_ADDR_FMT, 8'h08);
    wr(`AST_ADDR_ENA, 8'h26);
    peer.send(9'h012, 1'b1, -1);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    peer.send(9'h092, 1'b1, -1);
    rchk(`AST_ADDR_ENA, 8'hFF, 8'h24);
    rchk(`AST_ADDR_DATA, 8'hFF, 8'h92);
    drain();
    wr(`AST_ADDR_FMT, 8'h00);
    // Sleep is entered inside a character so no idle stretch precedes it.
    fork
      peer.send(9'h011, 1'b1, -1);
      begin
        bits(2);
        wr(`AST_ADDR_ENA, 8'h06);
      end
    join
    peer.send(9'h022, 1'b1, -1);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    bits(12);
    rchk(`AST_ADDR_ENA, 8'hFF, 8'h04);
    rchk(`AST_ADDR_STAT, 8'hFF, 8'hC0);
    done("wake");
    wr(`AST_ADDR_BAUD, 8'h01);
    rate_sel <= 5'h01;
    wr(`AST_ADDR_ENA, 8'h0C);
    fork
      peer.send(9'h07E, 1'b1, -1);
      begin
        wr(`AST_ADDR_DATA, 8'h81);
        bits(13);
      end
    join
    pop(10'h281);
    rchk(`AST_ADDR_DATA, 8'hFF, 8'h7E);
    done("rate");
    final_report();
  end
endmodule : ast_serial_tb_top
`default_nettype wire

// file: ast_vote.sv
// Majority voter over three line samples with a disagreement flag.
`timescale 1ns/100ps
`default_nettype none
module ast_vote (
  input  wire logic [2:0] samples,
  output logic            level,
  output logic            noisy
);
  assign level = (samples[0] & samples[1]) | (samples[0] & samples[2]) |
                 (samples[1] & samples[2]);
  assign noisy = (|samples) & ~(&samples);
endmodule : ast_vote
`default_nettype wire
